// ==== hw/ptp_pkg.sv ====
// Package for the pixel thread payload builder: register map, field positions,
// section codes and the carrier structs.
// Assumes a single clock domain shared by the window unit, the buffer and the bus.
package ptp_pkg;

   // ---------------------------------------------------------------
   // Widths and payload geometry
   // ---------------------------------------------------------------
   localparam int DW_W       = 32;
   localparam int DW_IDX_W   = 3;
   localparam int PX_N       = 16;
   localparam int BUF_ADDR_W = 16;
   localparam int TID_W      = 24;
   localparam int FIXED_FN_THREAD_TAG_W    = 8;
   localparam int COLOR_W    = 2;
   localparam int AXI_ADDR_W = 8;

   // ---------------------------------------------------------------
   // Register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [AXI_ADDR_W-1:0] REG_CTRL         = 8'h00;
   localparam logic [AXI_ADDR_W-1:0] REG_START_SLOT   = 8'h04;
   localparam logic [AXI_ADDR_W-1:0] REG_CONST_HANDLE = 8'h08;
   localparam logic [AXI_ADDR_W-1:0] REG_CONST_OFF    = 8'h0c;
   localparam logic [AXI_ADDR_W-1:0] REG_CONST_LEN    = 8'h10;
   localparam logic [AXI_ADDR_W-1:0] REG_SETUP_OFF    = 8'h14;
   localparam logic [AXI_ADDR_W-1:0] REG_SETUP_LEN    = 8'h18;
   localparam logic [AXI_ADDR_W-1:0] REG_SCRATCH_PTR  = 8'h1c;
   localparam logic [AXI_ADDR_W-1:0] REG_BINDING_PTR  = 8'h20;
   localparam logic [AXI_ADDR_W-1:0] REG_SAMPLER_PTR  = 8'h24;
   localparam logic [AXI_ADDR_W-1:0] REG_STATUS       = 8'h28;

   localparam int CTRL_ALPHA8_BIT = 0;
   localparam int STATUS_BUSY_BIT = 31;
   localparam int SCRATCH_LSB     = 10;
   localparam int PTR_LSB         = 5;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ---------------------------------------------------------------
   // Dword positions inside a row
   // ---------------------------------------------------------------
   localparam logic [DW_IDX_W-1:0] DW_LAST      = 3'h7;
   localparam logic [DW_IDX_W-1:0] HDR_SAMPLER  = 3'h3;
   localparam logic [DW_IDX_W-1:0] HDR_BINDING  = 3'h4;
   localparam logic [DW_IDX_W-1:0] HDR_IDS      = 3'h5;
   localparam logic [DW_IDX_W-1:0] HDR_TID      = 3'h6;
   localparam logic [DW_IDX_W-1:0] HDR_PTID     = 3'h7;
   localparam logic [DW_IDX_W-1:0] MASK_DW      = 3'h0;
   localparam logic [DW_IDX_W-1:0] COORD_DW0    = 3'h2;
   localparam logic [DW_IDX_W-1:0] COORD_DW3    = 3'h5;
   localparam logic [DW_IDX_W-1:0] ALPHA8_DW0   = 3'h4;
   localparam logic [DW_IDX_W-1:0] ALPHA4_DW0   = 3'h6;

   typedef enum logic [3:0] {
      SEC_IDLE, SEC_HDR, SEC_COORD, SEC_SDEP, SEC_AST, SEC_DDEP,
      SEC_PAD, SEC_CONST, SEC_SETUP
   } ptp_sec_t;

   typedef struct packed {
      logic [3:0][15:0]        ys;
      logic [3:0][15:0]        xs;
      logic [PX_N-1:0]         lit;
      logic                    d32;
      logic                    src_depth;
      logic                    alpha;
      logic                    stencil;
      logic                    dst_depth;
      logic [PX_N-1:0][31:0]   src_z;
      logic [PX_N-1:0][31:0]   dst_z;
      logic [PX_N-1:0][7:0]    alpha_px;
      logic [PX_N-1:0][7:0]    stencil_px;
      logic [BUF_ADDR_W-1:0]   setup_handle;
      logic [TID_W-1:0]        prim_tid;
   } ptp_disp_t;

   typedef struct packed {
      logic [DW_W-1:0] data;
      logic            last;
   } ptp_out_t;

endpackage : ptp_pkg

// ==== hw/ptp_payload_builder.sv ====
// Pixel thread payload builder: upper-half payload rows, buffer-sourced data and
// contiguous-dispatch header fields, streamed one dword per beat.
// Assumes window unit, return buffer and AXI4-Lite master share aclk; buffer reads
// return data while buf_rd_en stands, one cycle after the read is issued.
// Function
// [RQ1] Subspans 4..7 coordinates: Y high, X low, subspan 7 highest.
// [RQ2] Upper lit mask in bits 31:16, only on 32-pixel dispatches.
// [RQ3] Lit mask kept apart from dispatch mask with whole-subspan activity.
// [RQ4] Shader thread never changes the upper lit mask field.
// [RQ5] Low 16 bits carry a copy of lit mask; shader clears on kill.
// [RQ6] Source depth rows only with flag set and 32-pixel dispatch.
// [RQ7] Source depth floats ordered subspan 4,5 then 6,7; pixel order UL,UR,LL,LR.
// [RQ8] Alpha/stencil row if either flag on 32-pixel; each part valid by flag.
// [RQ9] 8-bit alpha: four bytes per word, pixel 3 on top.
// [RQ10] 4-bit alpha: eight nibbles per word in two words, others reserved.
// [RQ11] Stencil bytes four per word, pixel 3 on top, subspan 7 highest.
// [RQ12] Destination depth rows only with flag and 32-pixel, source ordering.
// [RQ13] Zero padding rows up to the buffer data start slot.
// [RQ14] Buffer-sourced data begins at fixed programmed slot regardless of header.
// [RQ15] Optional constant rows at programmed offset and length before setup.
// [RQ16] Setup rows last, from primitive handle at programmed offset and length.
// [RQ17] Setup rows pass coefficients through unchanged, four dwords per attribute.
// [RQ18] Software copies header dword 7 between rows on one variant.
// [RQ19] 24-bit thread count per dispatch plus primitive thread count.
// [RQ20] Scratch pointer in bits 31:10 of its dword.
// [RQ21] 2-bit sync tag and 8-bit thread identifier per thread.
// [RQ22] Binding table and sampler pointers in bits 31:5.
// [RQ23] Omitted groups leave no gaps; only padding precedes buffer data.
//
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
module ptp_payload_builder
   import ptp_pkg::*;
#(
   parameter int ROW_W = 6
)(
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [DW_W-1:0]       s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [DW_W-1:0]            s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   input  wire logic                  disp_valid,
   output logic                       disp_ready,
   input  wire ptp_disp_t             disp,
   output logic [PX_N-1:0]            disp_mask,
   output logic                       out_valid,
   input  wire logic                  out_ready,
   output ptp_out_t                   out,
   output logic                       buf_rd_en,
   output logic [BUF_ADDR_W-1:0]      buf_rd_addr,
   input  wire logic [DW_W-1:0]       buf_rd_data
);

   if (ROW_W < 2 || ROW_W + DW_IDX_W > BUF_ADDR_W)
   begin : g_bad_param
      $error("ptp_payload_builder: ROW_W out of range");
   end

   // ---------------------------------------------------------------
   // Register bus
   // ---------------------------------------------------------------
   logic                    alpha8;
   logic [ROW_W-1:0]        start_slot;
   logic [BUF_ADDR_W-1:0]   const_handle;
   logic [ROW_W-1:0]        const_off;
   logic [ROW_W-1:0]        const_len;
   logic [ROW_W-1:0]        setup_off;
   logic [ROW_W-1:0]        setup_len;
   logic [31:SCRATCH_LSB]   scratch_ptr;
   logic [31:PTR_LSB]       binding_ptr;
   logic [31:PTR_LSB]       sampler_ptr;
   logic [TID_W-1:0]        thread_cnt;
   ptp_sec_t                sec;
   logic                    aw_held;
   logic                    w_held;
   logic [AXI_ADDR_W-1:0]   aw_addr;
   logic [DW_W-1:0]         w_data;
   logic [3:0]              w_strb;

   function automatic logic [DW_W:0] reg_read(input logic [AXI_ADDR_W-1:0] a);
      logic [DW_W-1:0] d;
      logic            ok;
      d  = '0;
      ok = 1'b1;
      unique case (a)
         REG_CTRL:         d[CTRL_ALPHA8_BIT] = alpha8;
         REG_START_SLOT:   d[ROW_W-1:0] = start_slot;
         REG_CONST_HANDLE: d[BUF_ADDR_W-1:0] = const_handle;
         REG_CONST_OFF:    d[ROW_W-1:0] = const_off;
         REG_CONST_LEN:    d[ROW_W-1:0] = const_len;
         REG_SETUP_OFF:    d[ROW_W-1:0] = setup_off;
         REG_SETUP_LEN:    d[ROW_W-1:0] = setup_len;
         REG_SCRATCH_PTR:  d[31:SCRATCH_LSB] = scratch_ptr;
         REG_BINDING_PTR:  d[31:PTR_LSB] = binding_ptr;
         REG_SAMPLER_PTR:  d[31:PTR_LSB] = sampler_ptr;
         REG_STATUS:
         begin
            d[TID_W-1:0]       = thread_cnt;
            d[STATUS_BUSY_BIT] = (sec != SEC_IDLE);
         end
         default:          ok = 1'b0;
      endcase
      return {ok, d};
   endfunction : reg_read

   logic [DW_W:0]        wr_old_word;
   logic [DW_W:0]        rd_word;
   // A continuous assignment would miss register changes that the function reads inside.
   always_comb wr_old_word = reg_read(aw_addr);
   always_comb rd_word     = reg_read(s_axi_araddr);
   wire logic            wr_commit   = aw_held && w_held && !s_axi_bvalid;
   wire logic            aw_take     = s_axi_awvalid && s_axi_awready;
   wire logic            w_take      = s_axi_wvalid && s_axi_wready;
   wire logic            ar_take     = s_axi_arvalid && s_axi_arready;
   logic [DW_W-1:0]      wr_val;

   always_comb
   begin
      for (int b = 0; b < 4; b++)
         wr_val[b*8 +: 8] = w_strb[b] ? w_data[b*8 +: 8] : wr_old_word[b*8 +: 8];
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0; w_held <= 1'b0; aw_addr <= '0; w_data <= '0; w_strb <= '0;
         s_axi_awready <= 1'b1; s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0; s_axi_bresp <= RESP_OKAY;
      end
      else
      begin
         if (aw_take)
         begin
            aw_held <= 1'b1; aw_addr <= s_axi_awaddr; s_axi_awready <= 1'b0;
         end
         if (w_take)
         begin
            w_held <= 1'b1; w_data <= s_axi_wdata; w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_commit)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_old_word[DW_W] ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0; aw_held <= 1'b0; w_held <= 1'b0;
            s_axi_awready <= 1'b1; s_axi_wready <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         alpha8 <= 1'b0; start_slot <= '0; const_handle <= '0; const_off <= '0;
         const_len <= '0; setup_off <= '0; setup_len <= '0;
         scratch_ptr <= '0; binding_ptr <= '0; sampler_ptr <= '0;
      end
      else if (wr_commit)
      begin
         unique case (aw_addr)
            REG_CTRL:         alpha8 <= wr_val[CTRL_ALPHA8_BIT];
            REG_START_SLOT:   start_slot <= wr_val[ROW_W-1:0];
            REG_CONST_HANDLE: const_handle <= wr_val[BUF_ADDR_W-1:0];
            REG_CONST_OFF:    const_off <= wr_val[ROW_W-1:0];
            REG_CONST_LEN:    const_len <= wr_val[ROW_W-1:0];
            REG_SETUP_OFF:    setup_off <= wr_val[ROW_W-1:0];
            REG_SETUP_LEN:    setup_len <= wr_val[ROW_W-1:0];
            REG_SCRATCH_PTR:  scratch_ptr <= wr_val[31:SCRATCH_LSB];
            REG_BINDING_PTR:  binding_ptr <= wr_val[31:PTR_LSB];
            REG_SAMPLER_PTR:  sampler_ptr <= wr_val[31:PTR_LSB];
            default:          ;
         endcase
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b1; s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0; s_axi_rresp <= RESP_OKAY;
      end
      else if (ar_take)
      begin
         s_axi_arready <= 1'b0; s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word[DW_W-1:0];
         s_axi_rresp <= rd_word[DW_W] ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0; s_axi_arready <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Payload sequencer
   // ---------------------------------------------------------------
   ptp_disp_t               cur;
   logic [ROW_W-1:0]        srow;
   logic [ROW_W+1:0]        row_cnt;
   logic [DW_IDX_W-1:0]     dw;
   logic                    rd_pend;
   logic [COLOR_W-1:0]      color;
   logic [FIXED_FN_THREAD_TAG_W-1:0]      fixed_fn_thread_tag;
   ptp_sec_t                out_sec;
   logic [DW_IDX_W-1:0]     out_dw;
   logic [ROW_W+1:0]        out_row;
   ptp_sec_t                next_sec;
   logic [8:0]              present;
   logic                    sec_last_row;
   logic [DW_W-1:0]         gen_word;
   logic [DW_W-1:0]         alpha4_word;

   wire logic   disp_take = disp_valid && disp_ready;
   wire logic   is_buf    = (sec == SEC_CONST) || (sec == SEC_SETUP);
   wire logic   slot_free = !out_valid || out_ready;
   wire logic   step      = is_buf ? rd_pend : ((sec != SEC_IDLE) && slot_free);
   wire logic   rd_issue  = is_buf && slot_free && !rd_pend;
   wire logic   row_end   = step && (dw == DW_LAST);
   wire logic   pay_end   = row_end && sec_last_row && (next_sec == SEC_IDLE);
   wire logic [ROW_W+1:0]      rows_after = row_cnt + 1'b1;
   wire logic [1:0]            coord_idx  = 2'(dw - COORD_DW0);
   wire logic [3:0]            depth_idx  = {srow[0], dw};
   wire logic [BUF_ADDR_W-1:0] buf_base   = (sec == SEC_CONST) ? const_handle
                                                                : cur.setup_handle;
   wire logic [BUF_ADDR_W-1:0] buf_row    = BUF_ADDR_W'((sec == SEC_CONST) ? const_off
                                                                        : setup_off)
                                            + BUF_ADDR_W'(srow);
   wire logic [BUF_ADDR_W-1:0] next_addr  = buf_base + (buf_row << DW_IDX_W)
                                            + BUF_ADDR_W'(dw);

   // [RQ23] skip absent groups
   always_comb
   begin
      present = '0;
      present[SEC_COORD] = cur.d32;
      present[SEC_SDEP]  = cur.d32 && cur.src_depth;
      present[SEC_AST]   = cur.d32 && (cur.alpha || cur.stencil);
      present[SEC_DDEP]  = cur.d32 && cur.dst_depth;
      present[SEC_PAD]   = rows_after < (ROW_W+2)'(start_slot);
      present[SEC_CONST] = (const_len != '0);
      present[SEC_SETUP] = (setup_len != '0);
      next_sec = SEC_IDLE;
      for (int i = SEC_SETUP; i > int'(sec); i--)
         if (present[i])
            next_sec = ptp_sec_t'(4'(i));
   end

   always_comb
   begin
      unique case (sec)
         SEC_SDEP, SEC_DDEP: sec_last_row = srow[0];
         // [RQ13] pad until start slot
         SEC_PAD:            sec_last_row = !(rows_after < (ROW_W+2)'(start_slot));
         SEC_CONST:          sec_last_row = (srow == const_len - 1'b1);
         SEC_SETUP:          sec_last_row = (srow == setup_len - 1'b1);
         default:            sec_last_row = 1'b1;
      endcase
   end

   // [RQ10] nibble alpha pack
   always_comb
   begin
      alpha4_word = '0;
      for (int k = 0; k < 8; k++)
         alpha4_word[k*4 +: 4] = cur.alpha_px[{dw[0], 3'(k)}][7:4];
   end

   always_comb
   begin
      gen_word = '0;
      unique case (sec)
         SEC_HDR:
         begin
            // [RQ22] table pointers
            if (dw == HDR_SAMPLER) gen_word = {sampler_ptr, {PTR_LSB{1'b0}}};
            if (dw == HDR_BINDING) gen_word = {binding_ptr, {PTR_LSB{1'b0}}};
            // [RQ20] [RQ21] scratch and ids
            if (dw == HDR_IDS)     gen_word = {scratch_ptr, color, fixed_fn_thread_tag};
            // [RQ19] thread counts
            if (dw == HDR_TID)     gen_word = DW_W'(thread_cnt);
            if (dw == HDR_PTID)    gen_word = DW_W'(cur.prim_tid);
         end
         SEC_COORD:
         begin
            // [RQ2] [RQ5] lit mask and copy
            if (dw == MASK_DW) gen_word = {cur.lit, cur.lit};
            // [RQ1] subspan coordinates
            if (dw >= COORD_DW0 && dw <= COORD_DW3)
               gen_word = {cur.ys[coord_idx], cur.xs[coord_idx]};
         end
         // [RQ6] [RQ7] source depth order
         SEC_SDEP: gen_word = cur.src_z[depth_idx];
         SEC_AST:
         begin
            // [RQ11] stencil bytes
            if (dw < ALPHA8_DW0 && cur.stencil)
               gen_word = cur.stencil_px[{dw[1:0], 2'b00} +: 4];
            // [RQ9] byte alpha pack
            else if (dw >= ALPHA8_DW0 && cur.alpha && alpha8)
               gen_word = cur.alpha_px[{dw[1:0], 2'b00} +: 4];
            // [RQ8] alpha valid by flag
            else if (dw >= ALPHA4_DW0 && cur.alpha)
               gen_word = alpha4_word;
         end
         // [RQ12] destination depth order
         SEC_DDEP: gen_word = cur.dst_z[depth_idx];
         default:  gen_word = '0;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sec <= SEC_IDLE; srow <= '0; row_cnt <= '0; dw <= '0; cur <= '0;
         disp_ready <= 1'b1; disp_mask <= '0; thread_cnt <= '0; color <= '0;
         fixed_fn_thread_tag <= '0;
      end
      else if (disp_take)
      begin
         cur <= disp; sec <= SEC_HDR; srow <= '0; row_cnt <= '0; dw <= '0;
         disp_ready <= 1'b0;
         // [RQ19] [RQ21] per-thread tags
         thread_cnt <= thread_cnt + 1'b1;
         color <= color + 1'b1;
         fixed_fn_thread_tag <= fixed_fn_thread_tag + 1'b1;
         // [RQ3] whole-subspan dispatch mask
         for (int s = 0; s < 4; s++)
            disp_mask[s*4 +: 4] <= {4{|disp.lit[s*4 +: 4]}};
      end
      else if (step)
      begin
         dw <= dw + 1'b1;
         if (row_end)
         begin
            row_cnt <= rows_after;
            srow    <= sec_last_row ? '0 : srow + 1'b1;
            if (sec_last_row)
               sec <= next_sec;
            if (pay_end)
               disp_ready <= 1'b1;
         end
      end
   end

   // [RQ15] [RQ16] [RQ17] buffer reads
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         buf_rd_en <= 1'b0; buf_rd_addr <= '0; rd_pend <= 1'b0;
      end
      else
      begin
         buf_rd_en <= rd_issue;
         if (rd_issue)
            buf_rd_addr <= next_addr;
         rd_pend <= rd_issue;
      end
   end

   // [RQ14] buffer words follow
   wire logic [DW_W-1:0] out_word = is_buf ? buf_rd_data : gen_word;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         out_valid <= 1'b0; out <= '0; out_sec <= SEC_IDLE; out_dw <= '0;
         out_row <= '0;
      end
      else if (step)
      begin
         out_valid <= 1'b1; out.data <= out_word; out.last <= pay_end;
         out_sec <= sec; out_dw <= dw; out_row <= row_cnt;
      end
      else if (out_ready)
         out_valid <= 1'b0;
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_coord_word: assert property (out_valid && out_sec == SEC_COORD // [RQ1]
      && out_dw == COORD_DW0 |-> out.data == {cur.ys[0], cur.xs[0]})
      else $error("coordinate word wrong");
   a_mask_pair: assert property (out_valid && out_sec == SEC_COORD && out_dw == MASK_DW // [RQ5]
      |-> out.data[31:16] == out.data[15:0] && out.data[15:0] == cur.lit)
      else $error("lit mask word wrong");
   a_coord_gate: assert property (out_valid && out_sec == SEC_COORD |-> cur.d32) // [RQ2]
      else $error("mask row on 8-pixel dispatch");
   a_dispatch_mask: assert property (disp_take |=> disp_mask[3:0] == // [RQ3]
      ((|$past(disp.lit[3:0])) ? 4'hf : 4'h0)) else $error("dispatch mask wrong");
   a_sdep_gate: assert property (out_valid && out_sec == SEC_SDEP // [RQ6]
      |-> cur.d32 && cur.src_depth) else $error("source depth not gated");
   a_sdep_order: assert property (out_valid && out_sec == SEC_SDEP // [RQ7]
      |-> out.data == cur.src_z[{out_row[0], out_dw}]) else $error("source depth order wrong");
   a_ast_gate: assert property (out_valid && out_sec == SEC_AST // [RQ8]
      |-> cur.d32 && (cur.alpha || cur.stencil)) else $error("alpha row not gated");
   a_stencil_pack: assert property (out_valid && out_sec == SEC_AST && out_dw == 3'h3 // [RQ11]
      |-> out.data == (cur.stencil ? cur.stencil_px[15:12] : 32'h0))
      else $error("stencil word wrong");
   a_ddep_gate: assert property (out_valid && out_sec == SEC_DDEP // [RQ12]
      |-> cur.d32 && cur.dst_depth) else $error("destination depth not gated");
   a_pad_zero: assert property (out_valid && out_sec == SEC_PAD // [RQ13]
      |-> out.data == 32'h0 && out_row < (ROW_W+2)'(start_slot))
      else $error("padding wrong");
   a_buf_start: assert property (out_valid // [RQ14]
      && (out_sec == SEC_CONST || out_sec == SEC_SETUP)
      |-> out_row >= (ROW_W+2)'(start_slot)) else $error("buffer data too early");
   a_rd_return: assert property (buf_rd_en // [RQ17]
      |=> out_valid && out.data == $past(buf_rd_data)) else $error("buffer word not forwarded");
   a_tid_step: assert property (disp_take |=> thread_cnt == $past(thread_cnt) + 1'b1) // [RQ19]
      else $error("thread count not stepped");

   c_full_payload: cover property (out_valid && out_sec == SEC_DDEP && out.last == 1'b0);
   c_setup_last:   cover property (out_valid && out_sec == SEC_SETUP && out.last);
   c_pad_row:      cover property (out_valid && out_sec == SEC_PAD);
   c_backpressure: cover property (out_valid && !out_ready ##1 out_valid && out_ready);

endmodule : ptp_payload_builder

// ==== verif/ptp_thread_model.sv ====
// Far side model: shader thread sink plus return buffer read port.
// Assumes the builder's aclk; read data stands while buf_rd_en is high.
`timescale 1ns/100ps
module ptp_thread_model
   import ptp_pkg::*;
(
   input  wire logic                  aclk,
   input  wire logic                  buf_rd_en,
   input  wire logic [BUF_ADDR_W-1:0] buf_rd_addr,
   output logic [DW_W-1:0]            buf_rd_data,
   output logic                       out_ready
);
   logic phase = 1'h0;
   // The thread only reads; mask fields and header stay as delivered.
   // Stalls every other cycle; idle data never looks like a word, so a late capture shows.
   always @(posedge aclk)
      phase <= ~phase;
   assign out_ready   = phase;
   assign buf_rd_data = buf_rd_en ? {16'h5a00, buf_rd_addr} : {DW_W{phase}};
endmodule : ptp_thread_model

// ==== verif/tb_ptp_payload_builder.sv ====
// Testbench: registers over AXI4-Lite, two dispatches, payload checks.
// Assumes one clock; the thread model drives out_ready and buffer data.
`timescale 1ns/100ps
module tb_ptp_payload_builder import ptp_pkg::*;;
   logic       aclk = 1'h0, aresetn = 1'h0, awv = 1'h0, wv = 1'h0, bre = 1'h0;
   logic       arv = 1'h0, rre = 1'h0, dv = 1'h0, awr, wr_, bv, arr, rv, drdy, ov, ore, ren;
   logic [7:0] awa = '0, ara = '0;
   logic [31:0] wd = '0, rdat, rbd;
   logic [1:0] br, rr;
   logic [15:0] dmask, radr;
   ptp_disp_t  d = '0;
   ptp_out_t   o, q[$];
   int         errors = 0, n_checks = 0;
   always #50 aclk = ~aclk;
   always @(posedge aclk) if (ov && ore) q.push_back(o);
   ptp_payload_builder dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(br), .s_axi_bvalid(bv),
      .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre),
      .disp_valid(dv), .disp_ready(drdy), .disp(d), .disp_mask(dmask), .out_valid(ov),
      .out_ready(ore), .out(o), .buf_rd_en(ren), .buf_rd_addr(radr), .buf_rd_data(rbd));
   ptp_thread_model far (.aclk(aclk), .buf_rd_en(ren), .buf_rd_addr(radr),
      .buf_rd_data(rbd), .out_ready(ore));
   task automatic chk(input string nm, input logic [32:0] s, e);
      n_checks++;
      if (s !== e)
      begin
         errors++;
         $display("unexpected %s: expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic wrap_up;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : wrap_up
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      awa <= a; wd <= v; awv <= 1'h1; wv <= 1'h1; bre <= 1'h1;
      for (int k = 0; k < 50 && !(bre && bv); k++)
      begin
         @(posedge aclk);
         if (awr) awv <= 1'h0;
         if (wr_) wv <= 1'h0;
      end
      chk("bresp", {bv, br}, {1'h1, RESP_OKAY});
      bre <= 1'h0;
      @(posedge aclk);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
      ara <= a; arv <= 1'h1; rre <= 1'h1;
      for (int k = 0; k < 50 && !(rre && rv); k++)
      begin
         @(posedge aclk);
         if (arr) arv <= 1'h0;
      end
      chk("rdata", rdat, v);
      chk("rresp", rr, r);
      rre <= 1'h0;
      @(posedge aclk);
   endtask : rd
   function automatic ptp_disp_t mk(input logic [4:0] f);
      ptp_disp_t v = '0;
      for (int i = 0; i < 16; i++)
      begin
         v.src_z[i] = {28'h3f80000, i[3:0]}; v.dst_z[i] = {28'h4000000, i[3:0]};
         v.alpha_px[i] = {i[3:0], 4'h0}; v.stencil_px[i] = {4'h8, i[3:0]};
      end
      for (int i = 0; i < 4; i++) {v.ys[i], v.xs[i]} = {12'h010, i[3:0], 12'h020, i[3:0]};
      {v.d32, v.src_depth, v.alpha, v.stencil, v.dst_depth} = f;
      v.lit = 16'h0120; v.setup_handle = 16'h0100; v.prim_tid = 24'habcd;
      return v;
   endfunction : mk
   task automatic run(input logic [4:0] f, input int n);
      q.delete(); d <= mk(f); dv <= 1'h1;
      do @(posedge aclk); while (!drdy);
      dv <= 1'h0;
      for (int k = 0; k < 900 && q.size() < n; k++) @(posedge aclk);
      repeat (6) @(posedge aclk);
      chk("count", q.size(), n);
      chk("last", q[n-1].last, 1'h1);
   endtask : run
   task automatic t_full;
      rd(REG_CTRL, 0, RESP_OKAY);
      rd(8'h40, 0, RESP_SLVERR);
      wr(REG_SCRATCH_PTR, 32'h1400); wr(REG_BINDING_PTR, 32'h60); wr(REG_SAMPLER_PTR, 32'ha0);
      wr(REG_CTRL, 1); wr(REG_START_SLOT, 8); wr(REG_SETUP_OFF, 2); wr(REG_SETUP_LEN, 1);
      run(5'h1f, 72);
      chk("samp", q[3].data, 32'ha0);
      chk("bind", q[4].data, 32'h60);
      chk("scr", q[5].data[31:10], 5);
      chk("ids", q[5].data[9:0], 10'h101);
      chk("tid", q[6].data, 1);
      chk("ptid", q[7].data, 32'habcd);
      chk("dmask", dmask, 16'h0ff0);
      chk("lit", q[8].data, 32'h0120_0120);
      chk("xy7", q[13].data, 32'h0103_0203);
      chk("sz0", q[16].data, 32'h3f80_0000);
      chk("sz15", q[31].data, 32'h3f80_000f);
      chk("st7", q[35].data, 32'h8f8e_8d8c);
      chk("a8", q[36].data, 32'h3020_1000);
      chk("dz8", q[48].data, 32'h4000_0008);
      chk("pad", q[56].data, 0);
      chk("set", q[67].data, 32'h5a00_0113);
   endtask : t_full
   task automatic t_alpha4;
      wr(REG_CTRL, 0); wr(REG_START_SLOT, 0); wr(REG_CONST_HANDLE, 32'h0200);
      wr(REG_CONST_LEN, 1);
      run(5'h14, 40);
      chk("tid", q[6].data, 2);
      chk("ids", q[5].data[9:0], 10'h202);
      chk("st", q[16].data, 0);
      chk("res", q[20].data, 0);
      chk("a4lo", q[22].data, 32'h7654_3210);
      chk("a4hi", q[23].data, 32'hfedc_ba98);
      chk("const", q[24].data, 32'h5a00_0200);
      chk("set", q[35].data, 32'h5a00_0113);
   endtask : t_alpha4
   initial
   begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      t_full;
      t_alpha4;
      wrap_up;
   end
   initial
   begin
      repeat (4000) @(posedge aclk);
      errors++;
      wrap_up;
   end
endmodule : tb_ptp_payload_builder
